// ### verilog/trim_cfg.svh
`ifndef TRIM_CFG_SVH
`define TRIM_CFG_SVH

// register byte offsets
`define TRIM_AW            8
`define OFS_CTRL           8'h00
`define OFS_SET1_CFG       8'h04
`define OFS_SET2_CFG       8'h08
`define OFS_SET1_FAC       8'h0c
`define OFS_SET2_FAC       8'h10
`define OFS_MAX_SPEED      8'h14
`define OFS_MAX_TORQUE     8'h18
`define OFS_MAX_FREQ       8'h1c
`define OFS_STATUS         8'h20
`define OFS_TRIM_OUT       8'h24
`define OFS_USED_SPEED     8'h28
`define OFS_TORQUE_6       8'h2c

// control register fields
`define CTRL_AUTO_BIT      0
`define CTRL_SET_BIT       1
`define CTRL_SCALAR_BIT    2
`define CTRL_W             3

// per-set configuration fields
`define CFG_MODE_LO        0
`define CFG_MODE_HI        1
`define CFG_SRC_BIT        2
`define CFG_TGT_LO         3
`define CFG_TGT_HI         4
`define CFG_EN_BIT         5
`define CFG_W              6

// per-set factor fields, Q4.12 signed
`define FAC_ADJ_LO         0
`define FAC_ADJ_HI         15
`define FAC_MIX_LO         16
`define FAC_MIX_HI         31

// reset values
`define CTRL_RESET         3'h0
`define CFG_RESET          6'h00
`define FAC_RESET          32'h0000_1000

// arithmetic scaling
`define Q_FRAC             12
`define Q_ONE              32'sh0000_1000
`define SRC_FULL           32'sh0000_2710

// status word
`define STATUS_W           16
`define STATUS_TRIM_BIT    5

`endif

// ### verilog/trim_pkg.sv
package trim_pkg;

    typedef enum logic [1:0] {
        MODE_DIRECT,
        MODE_PROPORTIONAL,
        MODE_COMBINED
    } trim_mode_e;

    typedef enum logic [1:0] {
        TARGET_SPEED,
        TARGET_TORQUE,
        TARGET_FREQ
    } trim_target_e;

endpackage

// ### verilog/trim_if.sv
`timescale 1ns/1ps
interface trim_if #(
    parameter int DW = 24
);
    import trim_pkg::*;

    trim_mode_e           mode;
    logic signed [15:0]   src;
    logic signed [DW-1:0] ref_val;
    logic signed [DW-1:0] max_sel;
    logic signed [DW-1:0] max_speed;
    logic signed [15:0]   mix;
    logic signed [15:0]   adjust;
    logic signed [DW-1:0] trim;

    modport ctl (
        output mode,
        output src,
        output ref_val,
        output max_sel,
        output max_speed,
        output mix,
        output adjust,
        input  trim
    );

    modport calc (
        input  mode,
        input  src,
        input  ref_val,
        input  max_sel,
        input  max_speed,
        input  mix,
        input  adjust,
        output trim
    );
endinterface

// ### verilog/trim_compute.sv
`timescale 1ns/1ps
`include "trim_cfg.svh"
module trim_compute import trim_pkg::*; #(
    parameter int DW = 24
) (
    trim_if.calc bus
);
    localparam int PW = DW + 40;

    logic signed [PW-1:0] base;
    logic signed [PW-1:0] scaled;
    logic signed [PW-1:0] prod;

    always_comb begin
        unique case (bus.mode)
            MODE_DIRECT: begin
                base = PW'(bus.max_sel);
            end
            MODE_PROPORTIONAL: begin
                base = PW'(bus.ref_val);
            end
            MODE_COMBINED: begin
                // mix sets the zero-speed part, the rest scales with the reference
                base = (PW'(bus.max_speed) * PW'(bus.mix)
                       + (PW'(`Q_ONE) - PW'(bus.mix)) * PW'(bus.ref_val))
                       >>> `Q_FRAC;
            end
            default: begin
                base = '0;
            end
        endcase
        // source is in 0.01 % steps, so dividing by full scale 10000 gives the fraction
        scaled = (PW'(bus.src) * base) / PW'(`SRC_FULL);
        prod   = (scaled * PW'(bus.adjust)) >>> `Q_FRAC;
    end

    // no saturation: out-of-range results wrap, keep factors sane
    assign bus.trim = prod[DW-1:0];
endmodule

// ### verilog/trim_chain_add.sv
`timescale 1ns/1ps
module trim_chain_add #(
    parameter int DW = 24
) (
    input  wire logic signed [DW-1:0] base_a,
    input  wire logic signed [DW-1:0] base_b,
    input  wire logic signed [DW-1:0] trim,
    input  wire logic                 trim_en,
    output logic signed [DW-1:0]      sum
);
    always_comb begin
        sum = base_a + base_b + (trim_en ? trim : DW'(0));
    end
endmodule

// ### verilog/pid_trim_calculator.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "trim_cfg.svh"
module pid_trim_calculator import trim_pkg::*; #(
    parameter int DW = 24
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`TRIM_AW-1:0]    paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic signed [15:0]     pid_output,
    input  wire logic signed [15:0]     pid_setpoint,
    input  wire logic signed [DW-1:0]   trimmed_ref,
    input  wire logic signed [DW-1:0]   speed_ramp_out,
    input  wire logic signed [DW-1:0]   speed_correction,
    input  wire logic signed [DW-1:0]   torque_ref_5,
    input  wire logic signed [DW-1:0]   freq_ramp_out,
    input  wire logic                   ramp_stop_kind,
    input  wire logic                   emergency_ramp_stop_kind,
    output logic signed [DW-1:0]        trim_out,
    output logic signed [DW-1:0]        used_speed_ref,
    output logic signed [DW-1:0]        torque_ref_6,
    output logic signed [DW-1:0]        freq_ref_final,
    output logic [`STATUS_W-1:0]        pid_status_word
);

    ////////////////////////////////////////////////////////////////////////////
    // parameter check

    if (DW < 8 || DW > 32) begin : g_dw_check
        $error("pid_trim_calculator: DW must lie in 8..32");
    end

    // field macros must fit their words, or the decode below misreads them
    if (`CTRL_AUTO_BIT >= `CTRL_W || `CTRL_SET_BIT >= `CTRL_W) begin : g_ctrl_check
        $error("pid_trim_calculator: control field outside word");
    end

    if (`CTRL_SCALAR_BIT >= `CTRL_W) begin : g_scalar_check
        $error("pid_trim_calculator: scalar flag outside word");
    end

    if (`CFG_MODE_HI - `CFG_MODE_LO + 1 != $bits(trim_mode_e)) begin : g_mode_check
        $error("pid_trim_calculator: mode field width mismatch");
    end

    if (`CFG_TGT_HI - `CFG_TGT_LO + 1 != $bits(trim_target_e)) begin : g_tgt_check
        $error("pid_trim_calculator: target field width mismatch");
    end

    if (`CFG_EN_BIT >= `CFG_W || `CFG_SRC_BIT >= `CFG_W) begin : g_cfg_check
        $error("pid_trim_calculator: set field outside word");
    end

    if (`FAC_MIX_HI > 31 || `FAC_ADJ_HI >= `FAC_MIX_LO) begin : g_fac_check
        $error("pid_trim_calculator: factor fields overlap");
    end

    if (`FAC_ADJ_HI - `FAC_ADJ_LO != 15 || `FAC_MIX_HI - `FAC_MIX_LO != 15) begin : g_facw_check
        $error("pid_trim_calculator: factor fields must be 16 bits");
    end

    if (`STATUS_TRIM_BIT >= `STATUS_W || `STATUS_W > 32) begin : g_status_check
        $error("pid_trim_calculator: status bit outside word");
    end

    if (`OFS_TORQUE_6 >= (1 << `TRIM_AW)) begin : g_addr_check
        $error("pid_trim_calculator: register map exceeds address width");
    end

    if (`Q_FRAC >= 16) begin : g_frac_check
        $error("pid_trim_calculator: fraction bits exceed factor width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [`CTRL_W-1:0]    ctrl;
        logic [`CFG_W-1:0]     cfg1;
        logic [`CFG_W-1:0]     cfg2;
        logic [31:0]           fac1;
        logic [31:0]           fac2;
        logic signed [DW-1:0]  max_speed;
        logic signed [DW-1:0]  max_torque;
        logic signed [DW-1:0]  max_freq;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic signed [DW-1:0]  trim_out;
        logic signed [DW-1:0]  used_speed;
        logic signed [DW-1:0]  torque_6;
        logic signed [DW-1:0]  freq_final;
        logic [`STATUS_W-1:0]  status;
    } state_s;

    state_s cur;
    state_s next_state;

    ////////////////////////////////////////////////////////////////////////////
    // active set decode

    logic [`CFG_W-1:0]    set_cfg;
    logic [31:0]          set_fac;
    trim_mode_e           set_mode;
    trim_target_e         set_target;
    logic                 set_enable;
    logic                 stopping;
    logic                 connect;
    logic                 scalar;
    logic                 speed_en;
    logic                 torque_en;
    logic                 freq_en;
    logic signed [DW-1:0] speed_sum;
    logic signed [DW-1:0] torque_sum;
    logic signed [DW-1:0] freq_sum;
    logic                 access;

    always_comb begin
        set_cfg    = cur.ctrl[`CTRL_SET_BIT] ? cur.cfg2 : cur.cfg1;
        set_fac    = cur.ctrl[`CTRL_SET_BIT] ? cur.fac2 : cur.fac1;
        set_mode   = trim_mode_e'(set_cfg[`CFG_MODE_HI:`CFG_MODE_LO]);
        set_target = trim_target_e'(set_cfg[`CFG_TGT_HI:`CFG_TGT_LO]);
        set_enable = set_cfg[`CFG_EN_BIT];
        scalar     = cur.ctrl[`CTRL_SCALAR_BIT];
        // stop kinds are levels held for the whole stop
        stopping   = ramp_stop_kind | emergency_ramp_stop_kind;
        connect    = set_enable & cur.ctrl[`CTRL_AUTO_BIT] & ~stopping;
        speed_en   = connect & (set_target == TARGET_SPEED) & ~scalar;
        torque_en  = connect & (set_target == TARGET_TORQUE) & ~scalar;
        freq_en    = connect & (set_target == TARGET_FREQ) & scalar;
    end

    ////////////////////////////////////////////////////////////////////////////
    // trim arithmetic

    trim_if #(.DW(DW)) tbus ();

    always_comb begin
        tbus.mode      = set_mode;
        tbus.src       = set_cfg[`CFG_SRC_BIT] ? pid_setpoint : pid_output;
        tbus.ref_val   = trimmed_ref;
        tbus.max_speed = cur.max_speed;
        tbus.mix       = set_fac[`FAC_MIX_HI:`FAC_MIX_LO];
        tbus.adjust    = set_fac[`FAC_ADJ_HI:`FAC_ADJ_LO];
        unique case (set_target)
            TARGET_SPEED: begin
                tbus.max_sel = cur.max_speed;
            end
            TARGET_TORQUE: begin
                tbus.max_sel = cur.max_torque;
            end
            TARGET_FREQ: begin
                tbus.max_sel = cur.max_freq;
            end
            default: begin
                tbus.max_sel = '0;
            end
        endcase
    end

    trim_compute #(
        .DW (DW)
    ) u_compute (
        .bus (tbus.calc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reference chain adders

    trim_chain_add #(
        .DW (DW)
    ) u_speed_add (
        .base_a  (speed_ramp_out),
        .base_b  (speed_correction),
        .trim    (tbus.trim),
        .trim_en (speed_en),
        .sum     (speed_sum)
    );

    trim_chain_add #(
        .DW (DW)
    ) u_torque_add (
        .base_a  (torque_ref_5),
        .base_b  (DW'(0)),
        .trim    (tbus.trim),
        .trim_en (torque_en),
        .sum     (torque_sum)
    );

    trim_chain_add #(
        .DW (DW)
    ) u_freq_add (
        .base_a  (freq_ramp_out),
        .base_b  (DW'(0)),
        .trim    (tbus.trim),
        .trim_en (freq_en),
        .sum     (freq_sum)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    assign access = psel & penable & ~cur.pready;

    always_comb begin
        next_state         = cur;
        next_state.pready  = 1'b0;
        next_state.pslverr = 1'b0;

        // apb: one wait state, answer registered
        if (access) begin
            next_state.pready = 1'b1;
            next_state.prdata = 32'h0000_0000;
            case (paddr)
                `OFS_CTRL: begin
                    if (pwrite) begin
                        next_state.ctrl = pwdata[`CTRL_W-1:0];
                    end
                    next_state.prdata = 32'(cur.ctrl);
                end
                `OFS_SET1_CFG: begin
                    if (pwrite) begin
                        next_state.cfg1 = pwdata[`CFG_W-1:0];
                    end
                    next_state.prdata = 32'(cur.cfg1);
                end
                `OFS_SET2_CFG: begin
                    if (pwrite) begin
                        next_state.cfg2 = pwdata[`CFG_W-1:0];
                    end
                    next_state.prdata = 32'(cur.cfg2);
                end
                `OFS_SET1_FAC: begin
                    if (pwrite) begin
                        next_state.fac1 = pwdata;
                    end
                    next_state.prdata = cur.fac1;
                end
                `OFS_SET2_FAC: begin
                    if (pwrite) begin
                        next_state.fac2 = pwdata;
                    end
                    next_state.prdata = cur.fac2;
                end
                `OFS_MAX_SPEED: begin
                    if (pwrite) begin
                        next_state.max_speed = pwdata[DW-1:0];
                    end
                    next_state.prdata = 32'(cur.max_speed);
                end
                `OFS_MAX_TORQUE: begin
                    if (pwrite) begin
                        next_state.max_torque = pwdata[DW-1:0];
                    end
                    next_state.prdata = 32'(cur.max_torque);
                end
                `OFS_MAX_FREQ: begin
                    if (pwrite) begin
                        next_state.max_freq = pwdata[DW-1:0];
                    end
                    next_state.prdata = 32'(cur.max_freq);
                end
                // read-only words ignore writes quietly
                `OFS_STATUS: begin
                    next_state.prdata = 32'(cur.status);
                end
                `OFS_TRIM_OUT: begin
                    next_state.prdata = 32'(cur.trim_out);
                end
                `OFS_USED_SPEED: begin
                    next_state.prdata = 32'(cur.used_speed);
                end
                `OFS_TORQUE_6: begin
                    next_state.prdata = 32'(cur.torque_6);
                end
                default: begin
                    next_state.pslverr = 1'b1;
                end
            endcase
        end

        // datapath, refreshed every cycle
        next_state.trim_out   = tbus.trim;
        next_state.used_speed = speed_sum;
        next_state.torque_6   = torque_sum;
        next_state.freq_final = freq_sum;
        next_state.status     = '0;
        next_state.status[`STATUS_TRIM_BIT] = set_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur      <= '0;
            cur.ctrl <= `CTRL_RESET;
            cur.cfg1 <= `CFG_RESET;
            cur.cfg2 <= `CFG_RESET;
            cur.fac1 <= `FAC_RESET;
            cur.fac2 <= `FAC_RESET;
        end else begin
            cur <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata          = cur.prdata;
    assign pready          = cur.pready;
    assign pslverr         = cur.pslverr;
    assign trim_out        = cur.trim_out;
    assign used_speed_ref  = cur.used_speed;
    assign torque_ref_6    = cur.torque_6;
    assign freq_ref_final  = cur.freq_final;
    assign pid_status_word = cur.status;

endmodule

// ### dv/trim_chain_model.sv
`timescale 1ns/1ps
module trim_chain_model #(
    parameter int DW = 24
) (
    input  wire logic signed [DW-1:0] ext_speed_ref,
    output logic signed [DW-1:0]      trimmed_ref,
    output logic signed [DW-1:0]      speed_ramp_out,
    output logic signed [DW-1:0]      speed_correction,
    output logic signed [DW-1:0]      torque_ref_5,
    output logic signed [DW-1:0]      freq_ramp_out
);
    // trimmed ref and speed ref share one source, else proportional trim is off
    assign trimmed_ref      = ext_speed_ref;
    // zero ramp times, so ramp output tracks its reference at once
    assign speed_ramp_out   = ext_speed_ref;
    assign speed_correction = DW'(32'h0000_000a);
    assign torque_ref_5     = DW'(32'h0000_00c8);
    assign freq_ramp_out    = DW'(32'h0000_012c);
endmodule

// ### dv/pid_trim_monitor.sv
`timescale 1ns/1ps
`include "trim_cfg.svh"
module pid_trim_monitor import trim_pkg::*; #(
    parameter int DW = 24
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic signed [15:0]   pid_output,
    input wire logic signed [15:0]   pid_setpoint,
    input wire logic signed [DW-1:0] speed_ramp_out,
    input wire logic signed [DW-1:0] speed_correction,
    input wire logic signed [DW-1:0] torque_ref_5,
    input wire logic signed [DW-1:0] freq_ramp_out,
    input wire logic                 ramp_stop_kind,
    input wire logic                 emergency_ramp_stop_kind,
    input wire logic signed [DW-1:0] trim_out,
    input wire logic signed [DW-1:0] used_speed_ref,
    input wire logic signed [DW-1:0] torque_ref_6,
    input wire logic signed [DW-1:0] freq_ref_final,
    input wire logic [15:0]          pid_status_word
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence take_s;
        psel && penable && !pready;
    endsequence
    sequence stop_s;
        ramp_stop_kind || emergency_ramp_stop_kind;
    endsequence
    ////////////////////////////////////////////////////////////////
    apb_wait_a: assert property (take_s |=> pready && psel && penable)
        else $error("ready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    read_hold_a: assert property (!(psel && penable && !pready) |=> $stable(prdata))
        else $error("read data moved without access");
    stop_speed_a: assert property (stop_s |=>
        used_speed_ref == DW'($past(speed_ramp_out) + $past(speed_correction)))
        else $error("speed trim during stop");
    stop_torque_a: assert property (stop_s |=> torque_ref_6 == $past(torque_ref_5))
        else $error("torque trim during stop");
    stop_freq_a: assert property (stop_s |=> freq_ref_final == $past(freq_ramp_out))
        else $error("frequency trim during stop");
    zero_src_a: assert property ((pid_output == 16'sh0 && pid_setpoint == 16'sh0)
        |=> trim_out == '0) else $error("trim without source");
    status_bits_a: assert property
        ((pid_status_word & ~(16'h0001 << `STATUS_TRIM_BIT)) == 16'h0000)
        else $error("stray status bits");
endmodule
bind pid_trim_calculator pid_trim_monitor #(.DW(DW)) mon (
    .clk_sys                  (clk_sys),
    .rst_n                    (rst_n),
    .psel                     (psel),
    .penable                  (penable),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .pid_output               (pid_output),
    .pid_setpoint             (pid_setpoint),
    .speed_ramp_out           (speed_ramp_out),
    .speed_correction         (speed_correction),
    .torque_ref_5             (torque_ref_5),
    .freq_ramp_out            (freq_ramp_out),
    .ramp_stop_kind           (ramp_stop_kind),
    .emergency_ramp_stop_kind (emergency_ramp_stop_kind),
    .trim_out                 (trim_out),
    .used_speed_ref           (used_speed_ref),
    .torque_ref_6             (torque_ref_6),
    .freq_ref_final           (freq_ref_final),
    .pid_status_word          (pid_status_word)
);

// ### dv/pid_trim_calculator_tb_top.sv
`timescale 1ns/1ps
`include "trim_cfg.svh"
module pid_trim_calculator_tb_top import trim_pkg::*; ;
    localparam int     DW   = 24;
    localparam longint MSPD = 1500;
    localparam longint MTRQ = 800;
    localparam longint MFRQ = 500;
    typedef struct packed {
        logic [2:0]  ctrl;
        logic [5:0]  cfg;
        logic [31:0] fac;
        logic [15:0] po;
        logic [15:0] ps;
        logic [23:0] rf;
        logic [1:0]  stp;
    } case_s;
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ramp_stop_kind = 0, emergency_ramp_stop_kind = 0;
    logic signed [15:0] pid_output = 16'sh0, pid_setpoint = 16'sh0;
    logic signed [DW-1:0] ext_ref = 24'sh0, trimmed_ref, speed_ramp_out, speed_correction;
    logic signed [DW-1:0] torque_ref_5, freq_ramp_out, trim_out, used_speed_ref;
    logic signed [DW-1:0] torque_ref_6, freq_ref_final;
    logic [15:0] pid_status_word;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    always #10 clk_sys = ~clk_sys;
    pid_trim_calculator #(.DW(DW)) dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pid_output, .pid_setpoint, .trimmed_ref,
        .speed_ramp_out, .speed_correction, .torque_ref_5, .freq_ramp_out, .ramp_stop_kind,
        .emergency_ramp_stop_kind, .trim_out, .used_speed_ref, .torque_ref_6,
        .freq_ref_final, .pid_status_word);
    trim_chain_model #(.DW(DW)) far (.ext_speed_ref(ext_ref), .trimmed_ref, .speed_ramp_out,
        .speed_correction, .torque_ref_5, .freq_ramp_out);
    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // slave latency is not assumed: wait on pready, the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask
    function automatic longint exp_trim(input case_s c);
        longint src, base, mix, adj;
        src = c.cfg[2] ? longint'($signed(c.ps)) : longint'($signed(c.po));
        adj = longint'($signed(c.fac[15:0]));
        mix = longint'($signed(c.fac[31:16]));
        case (c.cfg[1:0])
            2'h0: base = (c.cfg[4:3] == 2'h0) ? MSPD : (c.cfg[4:3] == 2'h1) ? MTRQ :
                         (c.cfg[4:3] == 2'h2) ? MFRQ : 0;
            2'h1: base = longint'($signed(c.rf));
            2'h2: base = (MSPD * mix + (4096 - mix) * longint'($signed(c.rf))) >>> 12;
            default: return 0;
        endcase
        return ((src * base) / 10000 * adj) >>> 12;
    endfunction
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_sim;
        end
    end
    initial begin
        case_s tc[12];
        logic [7:0] s;
        logic signed [DW-1:0] t;
        logic [31:0] q;
        logic e, en, sc;
        logic [1:0] g;
        tc = '{'{3'h1, 6'h20, 32'h0000_0800, 16'h2710, 16'h0000, 24'h0002ee, 2'h0},
               '{3'h1, 6'h2d, 32'h0000_0800, 16'h0000, 16'h2710, 24'h0002ee, 2'h0},
               '{3'h5, 6'h32, 32'h019a_1000, 16'h2710, 16'h0000, 24'h0002ee, 2'h0},
               '{3'h5, 6'h22, 32'h019a_1000, 16'h2710, 16'h0000, 24'h000000, 2'h0},
               '{3'h1, 6'h32, 32'h019a_1000, 16'h2710, 16'h0000, 24'h0005dc, 2'h0},
               '{3'h0, 6'h20, 32'h0000_0800, 16'h2710, 16'h0000, 24'h0002ee, 2'h0},
               '{3'h3, 6'h28, 32'h0000_1000, 16'hec78, 16'h0000, 24'h0002ee, 2'h0},
               '{3'h1, 6'h20, 32'h0000_1000, 16'h2710, 16'h0000, 24'h0002ee, 2'h1},
               '{3'h1, 6'h20, 32'h0000_1000, 16'h2710, 16'h0000, 24'h0002ee, 2'h2},
               '{3'h1, 6'h23, 32'h0000_1000, 16'h2710, 16'h0000, 24'h0002ee, 2'h0},
               '{3'h1, 6'h38, 32'h0000_1000, 16'h2710, 16'h0000, 24'h0002ee, 2'h0},
               '{3'h1, 6'h00, 32'h0000_1000, 16'h2710, 16'h0000, 24'h0002ee, 2'h0}};
        repeat (16) @(posedge clk_sys);
        rst_n <= 1;
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_SET1_CFG, 32'h0);
        rd(`OFS_SET1_FAC, `FAC_RESET);
        rd(`OFS_SET2_FAC, `FAC_RESET);
        rd(`OFS_STATUS, 32'h0);
        apb(1'b0, 8'h30, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(`OFS_MAX_SPEED, 32'h0000_05dc);
        wr(`OFS_MAX_TORQUE, 32'h0000_0320);
        wr(`OFS_MAX_FREQ, 32'h0000_01f4);
        rd(`OFS_MAX_TORQUE, 32'h0000_0320);
        foreach (tc[i]) begin
            s = tc[i].ctrl[1] ? 8'h04 : 8'h00;
            wr(`OFS_CTRL, {29'h0, tc[i].ctrl});
            wr(`OFS_SET1_CFG + s, {26'h0, tc[i].cfg});
            wr(`OFS_SET2_CFG - s, 32'h0);
            wr(`OFS_SET1_FAC + s, tc[i].fac);
            wr(`OFS_SET2_FAC - s, `FAC_RESET);
            @(posedge clk_sys);
            pid_output <= tc[i].po;
            pid_setpoint <= tc[i].ps;
            ext_ref <= tc[i].rf;
            ramp_stop_kind <= tc[i].stp[0];
            emergency_ramp_stop_kind <= tc[i].stp[1];
            repeat (3) @(posedge clk_sys);
            #1;
            t = DW'(exp_trim(tc[i]));
            en = tc[i].ctrl[0] && tc[i].cfg[5] && tc[i].stp == 2'h0;
            sc = tc[i].ctrl[2];
            g = tc[i].cfg[4:3];
            chk(32'(trim_out), 32'(t));
            chk(32'(used_speed_ref), 32'(DW'($signed(tc[i].rf) + 10 +
                ((en && g == 2'h0 && !sc) ? t : 0))));
            chk(32'(torque_ref_6), 32'(DW'(200 + ((en && g == 2'h1 && !sc) ? t : 0))));
            chk(32'(freq_ref_final), 32'(DW'(300 + ((en && g == 2'h2 && sc) ? t : 0))));
            chk({16'h0, pid_status_word}, {26'h0, tc[i].cfg[5], 5'h0});
            wr(`OFS_TRIM_OUT, 32'h00ab_cdef);
            rd(`OFS_TRIM_OUT, 32'(t));
        end
        // mid-run reset must bring back the register defaults
        rst_n <= 0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1;
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_SET2_FAC, `FAC_RESET);
        rd(`OFS_MAX_SPEED, 32'h0);
        rd(`OFS_TRIM_OUT, 32'h0);
        end_sim;
    end
endmodule
